// ===== hw/sfc_top.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - Accept either clock idle level at select
// - Sample serial input on rising clock edge
// - Opcode then three address bytes, MSB first
// - Transfer or compare done within 250 us
// - Erase and program within their limits
// - Busy low within 200 ns of deselect
module sfc_top #(
    parameter int XFER_CYC_P   = sfc_pkg::XFER_CYC,        // Transfer time
    parameter int EP_CYC_P     = sfc_pkg::ERASE_PROG_CYC,  // Erase+program
    parameter int PROG_CYC_P   = sfc_pkg::PROG_CYC,        // Program only
    parameter int PERASE_CYC_P = sfc_pkg::PAGE_ERASE_CYC,  // Page erase
    parameter int BERASE_CYC_P = sfc_pkg::BLOCK_ERASE_CYC  // Block erase
) (
    // System clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        CE_I,
    // Serial link pins
    input  wire logic        CS_N_I,
    input  wire logic        SCK_I,
    input  wire logic        SI_I,
    output var  logic        RDY_BUSY_N_O,
    // Decoded command to user side
    output var  logic        CMD_VALID_O,
    output var  logic [7:0]  CMD_OPCODE_O,
    output var  logic [11:0] CMD_PAGE_ADDRESS_O,
    output var  logic [9:0]  CMD_BYTE_ADDRESS_O,
    output var  logic        CMD_RSV_ERR_O
);
    import sfc_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic cs_n_s;                       // Synchronised select
    logic sck_s;                        // Synchronised serial clock
    logic si_s;                         // Synchronised serial input

    sfc_sync u_cs (
        .clk_i     (REF_CLK_I),
        .arst_n_i  (ARST_N_I),
        .ce_i      (CE_I),
        .rst_val_i (1'b1),
        .d_i       (CS_N_I),
        .q_o       (cs_n_s)
    );
    sfc_sync u_sck (
        .clk_i     (REF_CLK_I),
        .arst_n_i  (ARST_N_I),
        .ce_i      (CE_I),
        .rst_val_i (1'b1),
        .d_i       (SCK_I),
        .q_o       (sck_s)
    );
    sfc_sync u_si (
        .clk_i     (REF_CLK_I),
        .arst_n_i  (ARST_N_I),
        .ce_i      (CE_I),
        .rst_val_i (1'b1),
        .d_i       (SI_I),
        .q_o       (si_s)
    );

    // ************************************************************
    // Edge and select detection
    // ************************************************************
    logic cs_n_d_reg;                   // Select, one cycle late
    logic sck_d_reg;                    // Clock, one cycle late
    wire  sck_rise  = sck_s & ~sck_d_reg & ~cs_n_s;  // Rising edge in frame
    wire  cs_fall   = cs_n_d_reg & ~cs_n_s;          // Frame start
    wire  cs_rise   = ~cs_n_d_reg & cs_n_s;          // Frame end

    // Edge history; sck_d_reg tracks the clock outside frames as well,
    // so a clock already resting high (mode 3) shows no edge at select
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cs_n_d_reg <= 1'b1;
            sck_d_reg  <= 1'b1;         // Same as synchroniser reset
        end else if (CE_I) begin
            cs_n_d_reg <= cs_n_s;
            sck_d_reg  <= sck_s;        // Either idle level works
        end
    end

    // ************************************************************
    // Frame shifter
    // ************************************************************
    logic [FRAME_BITS-1:0] shift_reg;   // Bits received, MSB first
    logic [BIT_CNT_W-1:0]  bits_reg;    // Bits received this frame
    wire                   bits_full = (bits_reg >= BIT_CNT_W'(FRAME_BITS));

    // Shift on each rising serial clock edge in frame until FRAME_BITS bits are held
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            shift_reg <= '0;
            bits_reg  <= '0;
        end else if (CE_I) begin
            if (cs_fall) begin
                bits_reg <= '0;         // New frame, clear count
            end else if (sck_rise && !bits_full) begin
                shift_reg <= {shift_reg[FRAME_BITS-2:0], si_s};
                bits_reg  <= bits_reg + BIT_CNT_W'(1);
            end
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    wire [7:0]  opc      = shift_reg[OPC_MSB:OPC_LSB];
    wire [1:0]  rsv      = shift_reg[RSV_MSB:RSV_LSB];
    wire [11:0] page_address = shift_reg[PAGE_MSB:PAGE_LSB];
    wire [9:0]  byte_address = shift_reg[BYTE_MSB:BYTE_LSB];

    // Operation length selected by opcode; zero means no operation
    logic [BUSY_CNT_W-1:0] op_len;
    always_comb begin
        case (opc)
            OPC_XFER1, OPC_XFER2,
            OPC_CMP1, OPC_CMP2:    op_len = BUSY_CNT_W'(XFER_CYC_P);
            OPC_RWR1, OPC_RWR2,
            OPC_EPRG1, OPC_EPRG2,
            OPC_MPRG1, OPC_MPRG2:  op_len = BUSY_CNT_W'(EP_CYC_P);
            OPC_PRG1, OPC_PRG2:    op_len = BUSY_CNT_W'(PROG_CYC_P);
            OPC_PERASE:            op_len = BUSY_CNT_W'(PERASE_CYC_P);
            OPC_BERASE:            op_len = BUSY_CNT_W'(BERASE_CYC_P);
            default:               op_len = '0;
        endcase
    end
    wire launch = cs_rise && bits_full && (op_len != '0);

    // ************************************************************
    // Busy state machine
    // ************************************************************
    sfc_state_type         state_reg;
    sfc_state_type         state_next;
    logic [BUSY_CNT_W-1:0] cnt_reg;     // Remaining busy cycles
    logic [BUSY_CNT_W-1:0] cnt_next;

    // Next state; new frames during busy are decoded but not launched
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            SFC_IDLE: begin
                if (launch) begin
                    state_next = SFC_BUSY;   // Busy next cycle
                    cnt_next   = op_len - BUSY_CNT_W'(1);
                end
            end
            SFC_BUSY: begin
                if (cnt_reg == '0) begin
                    state_next = SFC_IDLE;   // Operation done
                end else begin
                    cnt_next = cnt_reg - BUSY_CNT_W'(1);
                end
            end
            default: begin
                state_next = SFC_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_reg <= SFC_IDLE;
            cnt_reg   <= '0;
        end else if (CE_I) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Busy pin from a flop: low for the whole operation
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDY_BUSY_N_O <= BUSY_N_RST;
        end else if (CE_I) begin
            RDY_BUSY_N_O <= (state_next != SFC_BUSY);
        end
    end

    // ************************************************************
    // Command report to user side
    // ************************************************************
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CMD_VALID_O        <= 1'b0;
            CMD_OPCODE_O       <= '0;
            CMD_PAGE_ADDRESS_O <= '0;
            CMD_BYTE_ADDRESS_O <= '0;
            CMD_RSV_ERR_O      <= 1'b0;
        end else if (CE_I) begin
            CMD_VALID_O <= cs_rise && bits_full;   // One-cycle pulse
            if (cs_rise && bits_full) begin
                CMD_OPCODE_O       <= opc;
                CMD_PAGE_ADDRESS_O <= page_address;
                CMD_BYTE_ADDRESS_O <= byte_address;
                CMD_RSV_ERR_O      <= (rsv != 2'h0);  // Flags host slip
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_launch;
        launch && state_reg == SFC_IDLE && CE_I;
    endsequence

    a_busy_fast: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        s_launch |=> !RDY_BUSY_N_O)
        else $error("Busy not low after launch");

    a_busy_hold: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (state_reg == SFC_BUSY && cnt_reg != '0) |=> !RDY_BUSY_N_O)
        else $error("Busy released early");

    a_busy_end: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (state_reg == SFC_BUSY && cnt_reg == '0 && CE_I) |=> RDY_BUSY_N_O)
        else $error("Busy not released at end");

    a_count_limit: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        cnt_reg <= BUSY_CNT_W'(EP_CYC_P))
        else $error("Busy count beyond longest limit");

    a_xfer_len: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (s_launch and (opc == OPC_XFER1)) |=>
            (cnt_reg == BUSY_CNT_W'(XFER_CYC_P - 1)))
        else $error("Transfer length wrong");

    a_shift_edge: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (CE_I && sck_rise && !cs_fall && !bits_full) |=>
            shift_reg[0] == $past(si_s))
        else $error("Bit not sampled on rising edge");

    a_mode3_start: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (CE_I && cs_fall) |=> bits_reg == '0)
        else $error("Frame count not cleared");

    a_frame_len: assert property (
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        bits_reg <= BIT_CNT_W'(FRAME_BITS))
        else $error("Frame longer than four bytes");

endmodule

`default_nettype wire

// ===== hw/sfc_pkg.sv
package sfc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 20;          // System clock period
    localparam int BUSY_LAT_NS     = 200;         // Deselect to busy low, max
    localparam int BUSY_LAT_CYC    =
        (BUSY_LAT_NS / CLK_PERIOD_NS < 1) ? 1 : BUSY_LAT_NS / CLK_PERIOD_NS;
    localparam int XFER_US         = 250;         // Page to buffer, max
    localparam int XFER_LV_US      = 300;         // Low-voltage variant
    localparam int ERASE_PROG_MS   = 20;          // Erase plus program
    localparam int PROG_MS         = 14;          // Program only
    localparam int PAGE_ERASE_MS   = 8;           // Page erase
    localparam int BLOCK_ERASE_MS  = 12;          // Block erase
    // Longest times round down to whole cycles
    localparam int XFER_CYC        = XFER_US * 1000 / CLK_PERIOD_NS;
    localparam int XFER_LV_CYC     = XFER_LV_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_PROG_CYC  = ERASE_PROG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROG_CYC        = PROG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PAGE_ERASE_CYC  = PAGE_ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W      = 24;          // Width of busy counter

    // ************************************************************
    // Command frame layout
    // ************************************************************
    localparam int FRAME_BITS      = 32;          // Opcode plus three bytes
    localparam int BIT_CNT_W       = 6;
    localparam int OPC_MSB         = 31;
    localparam int OPC_LSB         = 24;
    localparam int RSV_MSB         = 23;
    localparam int RSV_LSB         = 22;
    localparam int PAGE_MSB        = 21;
    localparam int PAGE_LSB        = 10;
    localparam int BYTE_MSB        = 9;
    localparam int BYTE_LSB        = 0;

    // ************************************************************
    // Opcodes that start an internal operation on deselect
    // ************************************************************
    localparam logic [7:0] OPC_XFER1  = 8'h53;
    localparam logic [7:0] OPC_XFER2  = 8'h55;
    localparam logic [7:0] OPC_CMP1   = 8'h60;
    localparam logic [7:0] OPC_CMP2   = 8'h61;
    localparam logic [7:0] OPC_RWR1   = 8'h58;
    localparam logic [7:0] OPC_RWR2   = 8'h59;
    localparam logic [7:0] OPC_EPRG1  = 8'h83;
    localparam logic [7:0] OPC_EPRG2  = 8'h86;
    localparam logic [7:0] OPC_PRG1   = 8'h88;
    localparam logic [7:0] OPC_PRG2   = 8'h89;
    localparam logic [7:0] OPC_MPRG1  = 8'h82;
    localparam logic [7:0] OPC_MPRG2  = 8'h85;
    localparam logic [7:0] OPC_PERASE = 8'h81;
    localparam logic [7:0] OPC_BERASE = 8'h50;

    // Reset values
    localparam logic       BUSY_N_RST = 1'b1;     // Ready after reset

    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_LAUNCH,
        SFC_BUSY
    } sfc_state_type;

endpackage

// ===== hw/sfc_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for one bit
module sfc_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    input  wire logic rst_val_i,
    // Data
    input  wire logic d_i,
    output var  logic q_o
);
    logic meta_reg;                 // First stage, read only by second

    // ************************************************************
    // Two flops; both reset high, the idle level of select
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= 1'b1;
            q_o      <= 1'b1;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

    // rst_val_i is kept for port symmetry; idle pins sit high
    logic unused_rst;
    assign unused_rst = rst_val_i;

endmodule

`default_nettype wire

// ===== sim/sfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Host controller standing on the serial link
// ************************************************************
module sfc_host_model (
    // Clock
    input  wire logic clk_i,
    // Link pins
    output var  logic cs_n_o,
    output var  logic sck_o,
    output var  logic si_o
);
    localparam int HALF_CYC = 4;       // 80 ns half period of link clock
    localparam int GAP_CYC  = 13;      // Deselect gap, just over 250 ns

    // Select high from time zero, so reset release sees no frame
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    // One frame, top bit first; clock rests at idle_hi outside it
    task automatic send(input logic idle_hi, input logic [31:0] frame,
                        input int nbits);
        sck_o = idle_hi;
        repeat (GAP_CYC) @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (HALF_CYC) @(negedge clk_i);
        for (int i = 31; i > 31 - nbits; i--) begin
            sck_o = 1'b0;                      // Data moves on falling edge
            si_o  = frame[i];
            repeat (HALF_CYC) @(negedge clk_i);
            sck_o = 1'b1;                      // Device samples here
            repeat (HALF_CYC) @(negedge clk_i);
        end
        sck_o = idle_hi;                       // Clock stands still again
        repeat (HALF_CYC) @(negedge clk_i);
        cs_n_o = 1'b1;
        si_o   = ~si_o;                        // No stale bit once released
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_serial_flash_command_timing.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Self-checking bench for the command and busy timing
// ************************************************************
module tb_serial_flash_command_timing;
    import sfc_pkg::*;
    // Shortened operation lengths so the run stays brief
    localparam int XF = 20, EP = 40, PG = 30, PE = 10, BE = 15;
    localparam int TIMEOUT_CYC = 20000;   // Whole run needs about 6500
    localparam int PWR_CYC     = 100;     // Power-up wait, scaled down

    logic        ref_clk = 1'b0;          // System clock
    logic        arst_n  = 1'b0;          // Reset, active low
    logic        cs_n, sck, si;           // Link pins from host
    logic        rdy, vld, rsv;           // Device outputs
    logic [7:0]  opc_o;
    logic [11:0] page_o;
    logic [9:0]  byte_o;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc    = 0;
    logic [7:0]  opc_tab [14] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h58,
        8'h59, 8'h83, 8'h86, 8'h82, 8'h85, 8'h88, 8'h89, 8'h81, 8'h50};
    int          len_tab [14] = '{XF, XF, XF, XF, EP, EP, EP, EP, EP, EP,
        PG, PG, PE, BE};

    sfc_top #(.XFER_CYC_P(XF), .EP_CYC_P(EP), .PROG_CYC_P(PG),
              .PERASE_CYC_P(PE), .BERASE_CYC_P(BE)) i_dut (
        .REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .CE_I(1'b1),
        .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .RDY_BUSY_N_O(rdy),
        .CMD_VALID_O(vld), .CMD_OPCODE_O(opc_o),
        .CMD_PAGE_ADDRESS_O(page_o), .CMD_BYTE_ADDRESS_O(byte_o),
        .CMD_RSV_ERR_O(rsv));

    sfc_host_model i_host (.clk_i(ref_clk), .cs_n_o(cs_n), .sck_o(sck),
                           .si_o(si));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Hang guard: a run past the ceiling counts as a failure
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == TIMEOUT_CYC) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Compare helpers and closing report
    // ************************************************************
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("counts checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bounded wait for the decoded-command pulse after deselect
    task automatic wait_valid(output int lat);
        lat = 0;
        do begin
            @(negedge ref_clk);
            lat++;
        end while (vld !== 1'b1 && lat < 40);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic do_reset(input int hold);
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (hold) @(negedge ref_clk);
        cmp_val({21'h0, rdy, vld, rsv, opc_o}, {21'h0, 3'b100, 8'h00});
        cmp_val({10'h0, page_o, byte_o}, 32'h0);
        arst_n = 1'b1;
        repeat (50) @(negedge ref_clk);
        $display("test reset done");
    endtask

    // Launch opcode: latency, fields, busy length
    task automatic t_launch(input int idx, input logic idle_hi);
        logic [11:0] pg;
        logic [9:0]  ba;
        int          lat;
        int          busy;
        pg = 12'ha5c ^ 12'(idx);
        ba = 10'h3ff - 10'(idx);
        i_host.send(idle_hi, {opc_tab[idx], 2'b00, pg, ba}, 32);
        wait_valid(lat);
        cmp_cnt(int'(lat <= BUSY_LAT_CYC), 1);
        cmp_val(32'(rdy), 32'h0);
        cmp_val({1'b0, opc_o, page_o, byte_o, rsv},
                {1'b0, opc_tab[idx], pg, ba, 1'b0});
        busy = 0;
        while (rdy === 1'b0 && busy < 100) begin
            busy++;
            @(negedge ref_clk);
        end
        cmp_cnt(busy, len_tab[idx]);
        cmp_val(32'(rdy), 32'h1);
        $display("test launch %h done", opc_tab[idx]);
    endtask

    // Frame one bit short: nothing decoded, no busy
    task automatic t_short();
        i_host.send(1'b1, {8'h53, 24'h0}, 31);
        repeat (12) begin
            @(negedge ref_clk);
            cmp_val({30'h0, vld, rdy}, 32'h1);
        end
        $display("test short frame done");
    endtask

    // Opcode without internal work, reserved bits set
    task automatic t_other();
        int lat;
        i_host.send(1'b0, {8'h52, 2'b10, 12'h001, 10'h200}, 32);
        wait_valid(lat);
        cmp_cnt(int'(lat <= BUSY_LAT_CYC), 1);
        cmp_val({rsv, opc_o, page_o, byte_o}, {1'b1, 8'h52, 12'h001,
                10'h200, 1'b0} >> 1);
        repeat (EP) begin
            @(negedge ref_clk);
            cmp_val({30'h0, vld, rdy}, 32'h1);
        end
        $display("test other opcode done");
    endtask

    // Reset in the middle of an operation frees the busy line
    task automatic t_reset_busy();
        int lat;
        i_host.send(1'b0, {8'h83, 24'h0}, 32);
        wait_valid(lat);
        cmp_val(32'(rdy), 32'h0);
        do_reset(500);
        t_launch(12, 1'b0);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        do_reset(5);
        repeat (PWR_CYC) @(negedge ref_clk);
        for (int i = 0; i < 14; i++) begin
            t_launch(i, 1'(i));
        end
        t_short();
        t_launch(0, 1'b1);
        t_other();
        t_reset_busy();
        tally_and_finish();
    end
endmodule
`default_nettype wire
